// [logic/mq_device.sv]
// Overview of operation
// - almostEmptyFlag low when read queue almost empty
// - empty status bus shows four queues
// - flag mode captured during master reset
// - direct mode: strobe plus id picks device
// - polled mode steps devices, emits scan sync
// - almostFullFlag low when write queue almost full
// - full status bus direct or polled per edge
// - both status buses can release the lines
// - selected queue line mirrors single empty flag
// - select queue on both ports two cycles before clear
// - clear held low exactly one cycle
// - clear resets only that queue's pointers
// - read data is eighteen bits wide
// - word advances when enabled, output enabled, selected
// - read queue taken on select strobe edge
// - select strobe only during queue change cycles
// - never select strobe with device strobe
// - no read select before programming done
// - clock runs continuously, never gated
// - read select six bits, low two pick queue
// - bit two selects the null queue
// - top three bits compared with device id
// - previous queue word, then new queue word
// - output valid trails selection by two cycles
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module mq_device (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic [mq_pkg::ID_W-1:0]  deviceIdStrap,
  input  wire logic                     flagScanModeSelect,
  mq_link_if.dev                        link
);
  typedef struct packed {
    logic [mq_pkg::NUM_Q-1:0][mq_pkg::DEPTH-1:0][mq_pkg::DATA_W-1:0] mem;
    logic [mq_pkg::NUM_Q-1:0][mq_pkg::PTR_W:0]                         wrPtr;
    logic [mq_pkg::NUM_Q-1:0][mq_pkg::PTR_W:0]                         rdPtr;
    logic [mq_pkg::ID_W-1:0]                                           devId;
    mq_pkg::flag_mode_t                                                mode;
    logic [mq_pkg::QSEL_W-1:0]                                         wrQ;
    logic                                                              wrSel;
    logic [mq_pkg::QSEL_W-1:0]                                         rdQ;
    logic                                                              rdSel;
    logic [mq_pkg::QSEL_W-1:0]                                         prevQ;
    logic                                                              prevSel;
    logic [1:0]                                                        selPhase;
    logic [mq_pkg::DATA_W-1:0]                                         dataOut;
    logic                                                              outValid;
    logic [4:0]                                                        progCnt;
    logic                                                              aeFlag;
    logic                                                              afFlag;
  } dev_state_t;

  dev_state_t s_q;
  dev_state_t s_d;

  logic [mq_pkg::NUM_Q-1:0]  aeN;
  logic [mq_pkg::NUM_Q-1:0]  afN;
  logic [mq_pkg::PTR_W:0]    cnt [mq_pkg::NUM_Q];
  logic [mq_pkg::QSEL_W-1:0] popQ;
  logic                      popReq;
  logic                      rdMatch;
  logic                      wrMatch;
  logic                      estrMatch;

  // ----------------------------------------------------------------
  // per-queue occupancy and active-low almost flags
  // ----------------------------------------------------------------
  always_comb begin
    for (int q = 0; q < mq_pkg::NUM_Q; q++) begin
      cnt[q] = mq_pkg::fillCount(s_q.wrPtr[q], s_q.rdPtr[q]);
      aeN[q] = ~(cnt[q] <= mq_pkg::AE_LEVEL);
      afN[q] = ~(cnt[q] >= mq_pkg::AF_LEVEL);
    end
  end

  // address decode for both select buses
  assign rdMatch = mq_pkg::idMatch(link.readSelectBus[mq_pkg::RD_ADDR_W-1:mq_pkg::RD_ID_LSB], s_q.devId);
  assign wrMatch = mq_pkg::idMatch(link.writeSelectBus[mq_pkg::WR_ADDR_W-1:mq_pkg::WR_ID_LSB], s_q.devId);
  assign estrMatch = link.emptyFlagDeviceStrobe & (s_q.mode == mq_pkg::FLAG_DIRECT);

  // ----------------------------------------------------------------
  // read pipeline source: old queue, then new queue, then by enables
  // ----------------------------------------------------------------
  always_comb begin
    popQ   = s_q.rdQ;
    popReq = 1'b0;
    unique case (s_q.selPhase)
      2'h2: begin
        popQ   = s_q.prevQ;
        popReq = s_q.prevSel;
      end
      2'h1: begin
        popReq = s_q.rdSel;
      end
      2'h0: begin
        popReq = s_q.rdSel & ~link.readEnable_n & ~link.outputEnable_n;
      end
      default: begin
        popReq = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // programming is outside this block; done is a fixed count
    if (s_q.progCnt != '0) begin
      s_d.progCnt = s_q.progCnt - 5'h1;
    end

    // write select and write
    if (link.writeQueueSelectStrobe) begin
      s_d.wrSel = wrMatch;
      s_d.wrQ   = link.writeSelectBus[mq_pkg::QSEL_W-1:0];
    end
    if (!link.writeEnable_n && s_q.wrSel && cnt[s_q.wrQ] != mq_pkg::DEPTH_CNT) begin
      s_d.mem[s_q.wrQ][s_q.wrPtr[s_q.wrQ][mq_pkg::PTR_W-1:0]] = link.writeData;
      s_d.wrPtr[s_q.wrQ] = s_q.wrPtr[s_q.wrQ] + 4'h1;
    end

    // read queue select; the selected pipeline runs on from the old queue
    if (s_q.selPhase != 2'h0) begin
      s_d.selPhase = s_q.selPhase - 2'h1;
    end
    if (link.readQueueSelectStrobe) begin
      s_d.prevQ    = s_q.rdQ;
      s_d.prevSel  = s_q.rdSel;
      s_d.rdQ      = link.readSelectBus[mq_pkg::QSEL_W-1:0];
      s_d.rdSel    = rdMatch & ~link.readSelectBus[mq_pkg::RD_NULL_BIT];
      s_d.selPhase = mq_pkg::SEL_PIPE;
    end

    // output register: eighteen bits, advanced only on a pop
    if (popReq) begin
      s_d.outValid = (cnt[popQ] != '0);
      if (cnt[popQ] != '0) begin
        s_d.dataOut     = s_q.mem[popQ][s_q.rdPtr[popQ][mq_pkg::PTR_W-1:0]];
        s_d.rdPtr[popQ] = s_q.rdPtr[popQ] + 4'h1;
      end
    end else if (s_q.selPhase == 2'h1) begin
      s_d.outValid = 1'b0;
    end

    // pointer clear of the queue selected on the write port; config untouched
    if (!link.queuePointerClear_n && s_q.wrSel) begin
      s_d.wrPtr[s_q.wrQ] = '0;
      s_d.rdPtr[s_q.wrQ] = '0;
      if (s_q.wrQ == s_q.rdQ) begin
        s_d.outValid = 1'b0;
      end
    end

    // single flags registered from the same counts the buses see
    s_d.aeFlag = ~s_q.rdSel | aeN[s_q.rdQ];
    s_d.afFlag = ~s_q.wrSel | afN[s_q.wrQ];

    // master reset captures the straps; sync reset so ports are legal here
    if (srst) begin
      s_d         = '0;
      s_d.devId   = deviceIdStrap;
      s_d.mode    = flagScanModeSelect ? mq_pkg::FLAG_POLLED : mq_pkg::FLAG_DIRECT;
      s_d.progCnt = mq_pkg::PROG_CYCLES;
      s_d.aeFlag  = 1'b1;
      s_d.afFlag  = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // status buses
  // ----------------------------------------------------------------
  // empty side: device picked by its strobe and the read id field
  flag_bus_port emptyBus (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .polled   (s_q.mode == mq_pkg::FLAG_POLLED),
    .devId    (s_q.devId),
    .strobe   (estrMatch),
    .selId    (link.readSelectBus[mq_pkg::RD_ADDR_W-1:mq_pkg::RD_ID_LSB]),
    .flagsN   (aeN),
    .busOut   (link.almostEmptyStatusBus),
    .busOe_n  (link.emptyBusOe_n),
    .scanSync (link.emptyScanSync)
  );

  // full side: picked with full strobe and write select bus
  flag_bus_port fullBus (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .polled   (s_q.mode == mq_pkg::FLAG_POLLED),
    .devId    (s_q.devId),
    .strobe   (link.fullFlagDeviceStrobe & (s_q.mode == mq_pkg::FLAG_DIRECT)),
    .selId    (link.writeSelectBus[mq_pkg::WR_ADDR_W-1:mq_pkg::WR_ID_LSB]),
    .flagsN   (afN),
    .busOut   (link.almostFullStatusBus),
    .busOe_n  (link.fullBusOe_n),
    .scanSync (link.fullScanSync)
  );

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  // data lines float unless this device holds the read port or held it before the last select; valid floats once it has handed over
  assign link.readData            = s_q.dataOut;
  assign link.readDataOe_n        = link.outputEnable_n | ~(s_q.rdSel | s_q.prevSel);
  assign link.outputValid_n       = ~s_q.outValid;
  assign link.outputValidOe_n     = ~(s_q.rdSel | (s_q.prevSel & (s_q.selPhase != 2'h0)));
  assign link.almostEmptyFlag     = s_q.aeFlag;
  assign link.almostFullFlag      = s_q.afFlag;
  assign link.serialProgramDone_n = (s_q.progCnt != '0);
endmodule // mq_device

// [logic/mq_pkg.sv]
package mq_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_Q     = 4;
  localparam int DATA_W    = 18;
  localparam int DEPTH     = 8;
  localparam int PTR_W     = 3;
  localparam int QSEL_W    = 2;
  localparam int ID_W      = 3;
  localparam int RD_ADDR_W = 6;
  localparam int WR_ADDR_W = 5;
  // ----------------------------------------------------------------
  // field positions on the select buses
  // ----------------------------------------------------------------
  localparam int RD_NULL_BIT = 2;
  localparam int RD_ID_LSB   = 3;
  localparam int WR_ID_LSB   = 2;
  // ----------------------------------------------------------------
  // thresholds, counts and reset values
  // ----------------------------------------------------------------
  localparam logic [PTR_W:0]  AE_LEVEL    = 4'h2;
  localparam logic [PTR_W:0]  AF_LEVEL    = 4'h6;
  localparam logic [PTR_W:0]  DEPTH_CNT   = 4'h8;
  localparam logic [4:0]      PROG_CYCLES = 5'h10;
  localparam logic [1:0]      CLEAR_LEAD  = 2'h2;
  localparam logic [1:0]      SEL_PIPE    = 2'h2;
  localparam logic [ID_W-1:0] SCAN_FIRST  = 3'h0;

  typedef enum logic {FLAG_DIRECT, FLAG_POLLED} flag_mode_t;

  // occupancy of a queue from its wrapped pointers
  function automatic logic [PTR_W:0] fillCount(input logic [PTR_W:0] wp, input logic [PTR_W:0] rp);
    return PTR_W'(0) + (wp - rp);
  endfunction

  // device identity field compare, shared by both select buses
  function automatic logic idMatch(input logic [ID_W-1:0] a, input logic [ID_W-1:0] b);
    return a == b;
  endfunction
endpackage

// [logic/mq_link_if.sv]
`timescale 1ns/1ps
interface mq_link_if;
  // write port
  logic [mq_pkg::DATA_W-1:0]    writeData;
  logic                         writeEnable_n;
  logic [mq_pkg::WR_ADDR_W-1:0] writeSelectBus;
  logic                         writeQueueSelectStrobe;
  logic                         fullFlagDeviceStrobe;
  logic                         queuePointerClear_n;
  // read port
  logic [mq_pkg::RD_ADDR_W-1:0] readSelectBus;
  logic                         readQueueSelectStrobe;
  logic                         emptyFlagDeviceStrobe;
  logic                         readEnable_n;
  logic                         outputEnable_n;
  // device outputs, three-state ones carry an active-low enable
  logic [mq_pkg::DATA_W-1:0]    readData;
  logic                         readDataOe_n;
  logic                         outputValid_n;
  logic                         outputValidOe_n;
  logic                         almostEmptyFlag;
  logic                         almostFullFlag;
  logic [mq_pkg::NUM_Q-1:0]     almostEmptyStatusBus;
  logic                         emptyBusOe_n;
  logic [mq_pkg::NUM_Q-1:0]     almostFullStatusBus;
  logic                         fullBusOe_n;
  logic                         emptyScanSync;
  logic                         fullScanSync;
  logic                         serialProgramDone_n;

  modport dev (
    input  writeData, writeEnable_n, writeSelectBus, writeQueueSelectStrobe, fullFlagDeviceStrobe,
           queuePointerClear_n, readSelectBus, readQueueSelectStrobe, emptyFlagDeviceStrobe,
           readEnable_n, outputEnable_n,
    output readData, readDataOe_n, outputValid_n, outputValidOe_n, almostEmptyFlag, almostFullFlag,
           almostEmptyStatusBus, emptyBusOe_n, almostFullStatusBus, fullBusOe_n, emptyScanSync,
           fullScanSync, serialProgramDone_n
  );
  modport ctl (
    output writeData, writeEnable_n, writeSelectBus, writeQueueSelectStrobe, fullFlagDeviceStrobe,
           queuePointerClear_n, readSelectBus, readQueueSelectStrobe, emptyFlagDeviceStrobe,
           readEnable_n, outputEnable_n,
    input  readData, readDataOe_n, outputValid_n, outputValidOe_n, almostEmptyFlag, almostFullFlag,
           almostEmptyStatusBus, emptyBusOe_n, almostFullStatusBus, fullBusOe_n, emptyScanSync,
           fullScanSync, serialProgramDone_n
  );
endinterface

// [logic/flag_bus_port.sv]
`timescale 1ns/1ps
// one four-line status bus: direct device pick or polled scan
module flag_bus_port (
  input  wire logic                      ref_clk,
  input  wire logic                      srst,
  input  wire logic                      polled,
  input  wire logic [mq_pkg::ID_W-1:0]   devId,
  input  wire logic                      strobe,
  input  wire logic [mq_pkg::ID_W-1:0]   selId,
  input  wire logic [mq_pkg::NUM_Q-1:0]  flagsN,
  output logic      [mq_pkg::NUM_Q-1:0]  busOut,
  output logic                           busOe_n,
  output logic                           scanSync
);
  typedef struct packed {
    logic [mq_pkg::ID_W-1:0]  scanId;
    logic [mq_pkg::ID_W-1:0]  shownId;
    logic [mq_pkg::NUM_Q-1:0] busOut;
    logic                     drive;
    logic                     sync;
  } bus_state_t;

  bus_state_t s_q;
  bus_state_t s_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.busOut = flagsN;
    if (polled) begin
      // every device steps the same counter, so the chain shares slots
      s_d.scanId = s_q.scanId + 3'h1;
      s_d.drive  = mq_pkg::idMatch(s_q.scanId, devId);
      s_d.sync   = (s_q.scanId == mq_pkg::SCAN_FIRST);
    end else begin
      if (strobe) begin
        s_d.shownId = selId;
      end
      s_d.drive = mq_pkg::idMatch(strobe ? selId : s_q.shownId, devId);
      s_d.sync  = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busOut   = s_q.busOut;
  assign busOe_n  = ~s_q.drive;
  assign scanSync = s_q.sync;
endmodule // flag_bus_port

// [logic/mq_controller.sv]
`timescale 1ns/1ps
// reading and writing controller facing the queue device
module mq_controller (
  input  wire logic                          ref_clk,
  input  wire logic                          srst,
  input  wire logic                          cmdWrite,
  input  wire logic [mq_pkg::DATA_W-1:0]     cmdData,
  input  wire logic                          cmdWrSelect,
  input  wire logic [mq_pkg::WR_ADDR_W-1:0]  cmdWrAddr,
  input  wire logic                          cmdFullPick,
  input  wire logic                          cmdRdSelect,
  input  wire logic                          cmdEmptyPick,
  input  wire logic [mq_pkg::RD_ADDR_W-1:0]  cmdRdAddr,
  input  wire logic                          cmdRead,
  input  wire logic                          cmdClear,
  output logic                               busy,
  output logic      [mq_pkg::DATA_W-1:0]     rdData,
  output logic                               rdValid,
  mq_link_if.ctl                             link
);
  typedef enum logic [1:0] {C_IDLE, C_LEAD, C_CLEAR} clr_state_t;

  typedef struct packed {
    clr_state_t                   st;
    logic [1:0]                   lead;
    logic [mq_pkg::DATA_W-1:0]    wData;
    logic                         wEn;
    logic [mq_pkg::WR_ADDR_W-1:0] wAddr;
    logic                         wSel;
    logic                         full_flag_device_strobe;
    logic [mq_pkg::RD_ADDR_W-1:0] rAddr;
    logic                         rSel;
    logic                         empty_flag_device_strobe;
    logic                         rEn;
    logic                         clr;
    logic [mq_pkg::DATA_W-1:0]    rData;
    logic                         rValid;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;
  logic       progDone;

  assign progDone = ~link.serialProgramDone_n;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.wData  = cmdData;
    s_d.wEn    = cmdWrite;
    s_d.wAddr  = cmdWrAddr;
    s_d.rAddr  = cmdRdAddr;
    s_d.rEn    = cmdRead;
    s_d.clr    = 1'b0;
    // strobes are single pulses; nothing selects before programming ends
    s_d.wSel   = cmdWrSelect & progDone;
    s_d.full_flag_device_strobe   = cmdFullPick & ~cmdWrSelect;
    s_d.rSel   = cmdRdSelect & progDone;
    s_d.empty_flag_device_strobe   = cmdEmptyPick & ~cmdRdSelect;
    s_d.rValid = ~link.outputValidOe_n & ~link.outputValid_n;
    if (s_d.rValid) begin
      s_d.rData = link.readData;
    end
    unique case (s_q.st)
      C_IDLE: begin
        if (cmdClear && progDone) begin
          // same queue goes on both ports before the clear
          s_d.wSel  = 1'b1;
          s_d.rSel  = 1'b1;
          s_d.full_flag_device_strobe  = 1'b0;
          s_d.empty_flag_device_strobe  = 1'b0;
          s_d.rAddr = {cmdWrAddr[mq_pkg::WR_ADDR_W-1:mq_pkg::WR_ID_LSB], 1'b0,
                       cmdWrAddr[mq_pkg::QSEL_W-1:0]};
          s_d.lead  = mq_pkg::CLEAR_LEAD;
          s_d.st    = C_LEAD;
        end
      end
      C_LEAD: begin
        s_d.wSel = 1'b0;
        s_d.rSel = 1'b0;
        s_d.lead = s_q.lead - 2'h1;
        if (s_q.lead == 2'h1) begin
          s_d.clr = 1'b1;
          s_d.st  = C_CLEAR;
        end
      end
      C_CLEAR: begin
        s_d.wSel = 1'b0;
        s_d.rSel = 1'b0;
        s_d.st   = C_IDLE;
      end
      default: begin
        s_d.st = C_IDLE;
      end
    endcase
    if (srst) begin
      s_d = '0;
    end
  end

  // ----------------------------------------------------------------
  // registers; ref_clk is free running toward the device
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // pins, all from flops except outputEnable_n, tied low, and busy, which ORs in ~progDone, the device's serialProgramDone_n pin
  // ----------------------------------------------------------------
  assign link.writeData              = s_q.wData;
  assign link.writeEnable_n          = ~s_q.wEn;
  assign link.writeSelectBus         = s_q.wAddr;
  assign link.writeQueueSelectStrobe = s_q.wSel;
  assign link.fullFlagDeviceStrobe   = s_q.full_flag_device_strobe;
  assign link.queuePointerClear_n    = ~s_q.clr;
  assign link.readSelectBus          = s_q.rAddr;
  assign link.readQueueSelectStrobe  = s_q.rSel;
  assign link.emptyFlagDeviceStrobe  = s_q.empty_flag_device_strobe;
  assign link.readEnable_n           = ~s_q.rEn;
  assign link.outputEnable_n         = 1'b0;
  assign busy                        = (s_q.st != C_IDLE) | ~progDone;
  assign rdData                      = s_q.rData;
  assign rdValid                     = s_q.rValid;
endmodule // mq_controller

// [tb/mq_link_props.sv]
`timescale 1ns/1ps
// watches the controller-device link; the device is strapped to id 0 here
module mq_link_props (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       queuePointerClear_n,
  input wire logic       readQueueSelectStrobe,
  input wire logic       emptyFlagDeviceStrobe,
  input wire logic [5:0] readSelectBus,
  input wire logic       serialProgramDone_n,
  input wire logic       outputValid_n,
  input wire logic       emptyBusOe_n,
  input wire logic       almostEmptyFlag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // link properties
  // ----------------------------------------------------------------
  // reset checks drop the default disable, as they must look during reset
  property p_rstBus; disable iff (1'b0) srst |=> emptyBusOe_n; endproperty
  a_rstBus: assert property (p_rstBus) else $error("status bus driven in reset");
  property p_rstFlag; disable iff (1'b0) srst |=> almostEmptyFlag && outputValid_n; endproperty
  a_rstFlag: assert property (p_rstFlag) else $error("flags active in reset");
  property p_clrOne; $fell(queuePointerClear_n) |=> queuePointerClear_n; endproperty
  a_clrOne: assert property (p_clrOne) else $error("clear held too long");
  property p_noBoth; !(readQueueSelectStrobe && emptyFlagDeviceStrobe); endproperty
  a_noBoth: assert property (p_noBoth) else $error("select and pick together");
  property p_progFirst; readQueueSelectStrobe |-> !serialProgramDone_n; endproperty
  a_progFirst: assert property (p_progFirst) else $error("select before programming");
  // null select: no data queue, so the valid flag must be off three edges on
  property p_nullSel;
    readQueueSelectStrobe && readSelectBus[2] ##1 (!readQueueSelectStrobe) [*2] |=> outputValid_n;
  endproperty
  a_nullSel: assert property (p_nullSel) else $error("valid after null select");
  property p_pickOwn;
    emptyFlagDeviceStrobe && readSelectBus[5:3] == 3'h0 ##1 !emptyFlagDeviceStrobe |-> ##[1:2] !emptyBusOe_n;
  endproperty
  a_pickOwn: assert property (p_pickOwn) else $error("picked device not driving");
  property p_pickOther;
    emptyFlagDeviceStrobe && readSelectBus[5:3] != 3'h0 ##1 !emptyFlagDeviceStrobe |-> ##[1:2] emptyBusOe_n;
  endproperty
  a_pickOther: assert property (p_pickOther) else $error("unpicked device driving");
  c_pick: cover property (emptyFlagDeviceStrobe);
  c_clr: cover property ($fell(queuePointerClear_n));
  c_sel: cover property (readQueueSelectStrobe && !readSelectBus[2]);
endmodule // mq_link_props

// [tb/multi_queue_read_port_and_flags_tb.sv]
`timescale 1ns/1ps
module multi_queue_read_port_and_flags_tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1, pollMode = 1'b0;
  logic        cmdWrite = 1'b0, cmdWrSelect = 1'b0, cmdFullPick = 1'b0, cmdRead = 1'b0;
  logic        cmdRdSelect = 1'b0, cmdEmptyPick = 1'b0, cmdClear = 1'b0, rdValid, busy;
  logic [17:0] cmdData = 18'h00000, rdData;
  logic [4:0]  cmdWrAddr = 5'h00;
  logic [5:0]  cmdRdAddr = 6'h00;
  int          errorCnt = 0, testsRun = 0;
  mq_link_if link ();
  // direct flag mode, single device at id 0
  mq_device i_mq_device (.ref_clk(ref_clk), .srst(srst), .deviceIdStrap(3'h0),
    .flagScanModeSelect(pollMode), .link(link));
  mq_controller i_mq_controller (.ref_clk(ref_clk), .srst(srst), .cmdWrite(cmdWrite),
    .cmdData(cmdData), .cmdWrSelect(cmdWrSelect), .cmdWrAddr(cmdWrAddr), .cmdFullPick(cmdFullPick),
    .cmdRdSelect(cmdRdSelect), .cmdEmptyPick(cmdEmptyPick), .cmdRdAddr(cmdRdAddr), .cmdRead(cmdRead),
    .cmdClear(cmdClear), .busy(busy), .rdData(rdData), .rdValid(rdValid), .link(link));
  mq_link_props i_mq_link_props (.ref_clk(ref_clk), .srst(srst),
    .queuePointerClear_n(link.queuePointerClear_n), .readQueueSelectStrobe(link.readQueueSelectStrobe),
    .emptyFlagDeviceStrobe(link.emptyFlagDeviceStrobe), .readSelectBus(link.readSelectBus),
    .serialProgramDone_n(link.serialProgramDone_n), .outputValid_n(link.outputValid_n),
    .emptyBusOe_n(link.emptyBusOe_n), .almostEmptyFlag(link.almostEmptyFlag));
  // 4 ns period
  initial forever #2 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ends 1 ns past the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one-cycle command; the address goes to both ports, then n cycles settle
  task automatic strobe(input int k, input logic [5:0] a, input int n);
    @(posedge ref_clk);
    cmdWrAddr <= a[4:0];
    cmdRdAddr <= a;
    {cmdWrSelect, cmdFullPick, cmdRdSelect, cmdEmptyPick, cmdClear} <= 5'h10 >> k;
    @(posedge ref_clk);
    {cmdWrSelect, cmdFullPick, cmdRdSelect, cmdEmptyPick, cmdClear} <= 5'h00;
    tick(n);
  endtask
  task automatic wr(input logic [17:0] d);
    @(posedge ref_clk);
    cmdWrite <= 1'b1;
    cmdData <= d;
    @(posedge ref_clk);
    cmdWrite <= 1'b0;
  endtask
  // a read enable pulse, then the word it brings; the wait is bounded
  task automatic rdWord(input logic doRead, input logic [17:0] exp);
    int i = 0;
    if (doRead) begin
      @(posedge ref_clk);
      cmdRead <= 1'b1;
      @(posedge ref_clk);
      cmdRead <= 1'b0;
      // rdValid stays up while valid holds, so let the old word pass first
      tick(2);
    end
    do begin
      tick(1);
      i++;
    end while (rdValid !== 1'b1 && i < 20);
    if (rdValid !== 1'b1) begin
      chk(18'h00000, 18'h00001);
      tally_and_finish();
    end
    chk(rdData, exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // three words through queue 1, first one falls through on select
  task automatic readPath();
    strobe(0, 6'h01, 6);
    wr(18'h0A001);
    wr(18'h0A002);
    wr(18'h0A003);
    strobe(2, 6'h01, 0);
    rdWord(1'b0, 18'h0A001);
    rdWord(1'b1, 18'h0A002);
    rdWord(1'b1, 18'h0A003);
    tick(4);
    chk(link.almostEmptyFlag, 1'b0);
    chk(link.readDataOe_n, 1'b0);
  endtask
  // queue 2 filled to almost full, both buses picked, foreign id, null queue
  task automatic flagPath();
    strobe(0, 6'h02, 6);
    repeat (6) wr(18'h0B00F);
    tick(3);
    chk(link.almostFullFlag, 1'b0);
    strobe(3, 6'h00, 6);
    chk(link.emptyBusOe_n, 1'b0);
    chk(link.almostEmptyStatusBus, 4'h4);
    strobe(1, 6'h02, 6);
    chk(link.almostFullStatusBus, 4'hB);
    strobe(3, 6'h08, 6);
    chk(link.emptyBusOe_n, 1'b1);
    strobe(2, 6'h04, 6);
    chk(link.outputValid_n, 1'b1);
  endtask
  // queue 3 holds three words while queue 2 is cleared
  task automatic clearPath();
    strobe(0, 6'h03, 6);
    repeat (3) wr(18'h0C003);
    strobe(4, 6'h02, 10);
    chk(link.almostFullFlag, 1'b1);
    chk(link.almostFullStatusBus, 4'hF);
    strobe(3, 6'h00, 6);
    chk(link.almostEmptyStatusBus, 4'h8);
  endtask
  // master reset into polled mode; the id 0 slot comes round every eight edges
  task automatic pollPath();
    int i = 0;
    @(posedge ref_clk);
    pollMode <= 1'b1;
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    do begin
      tick(1);
      i++;
    end while (link.emptyScanSync !== 1'b1 && i < 20);
    chk(link.emptyScanSync, 1'b1);
    chk(link.fullScanSync, 1'b1);
    chk(link.emptyBusOe_n, 1'b0);
    chk(busy, 1'b1);
    tick(1);
    chk(link.emptyBusOe_n, 1'b1);
    chk(link.emptyScanSync, 1'b0);
    tick(7);
    chk(link.emptyScanSync, 1'b1);
  endtask
  // main sequence; programming wait is bounded
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (40) if (link.serialProgramDone_n !== 1'b0) tick(1);
    chk(link.serialProgramDone_n, 1'b0);
    chk(busy, 1'b0);
    if (errorCnt != 0) tally_and_finish();
    readPath();
    flagPath();
    clearPath();
    pollPath();
    tally_and_finish();
  end
endmodule // multi_queue_read_port_and_flags_tb
